// ===== supervisor_pkg.sv
// Shared constants, types and timing counts for the supply supervisor and watchdog.
// Assumes a single 200 MHz clock and digital comparator indications from outside.
// How it works
// - Reset held low while supply below threshold.
// - In the dual-polarity variant the high reset output complements the low one.
// - Manual reset low starts a reset pulse.
// - Floating manual reset input counts as high.
// - Kick idle 1.6 s declares watchdog timeout.
// - Floating kick input disables the watchdog entirely.
// - Reset, floating kick or edges clear count.
// - Timeout output stays low until next clear.
// - Low supply forces watchdog output low immediately.
// - Power-fail output follows comparator against reference.
// - Dual-polarity variant has no watchdog function.
// - Supply dip restarts a running reset pulse.
// - Watchdog idle during reset, and its output high unless the supply is low.
`default_nettype none
package supervisor_pkg;

	// Clock and time base.
	localparam int CLK_FREQ_HZ     = 200_000_000;
	localparam int TIME_BASE_US    = 1000;
	localparam int TICK_CYCLES     = (CLK_FREQ_HZ / 1_000_000) * TIME_BASE_US;

	// Documented periods, in their own units, and their tick counts.
	localparam int RESET_PULSE_MS  = 200;
	localparam int WDOG_TIMEOUT_MS = 1600;
	localparam int PULSE_W         = 8;
	localparam int WDOG_W          = 11;
	localparam logic [PULSE_W-1:0] RESET_TICKS = PULSE_W'(RESET_PULSE_MS * 1000 / TIME_BASE_US);
	localparam logic [WDOG_W-1:0]  WDOG_TICKS  = WDOG_W'(WDOG_TIMEOUT_MS * 1000 / TIME_BASE_US);

	// Product variants: which reset polarity and whether a watchdog exists.
	typedef enum logic [1:0] {
		VAR_LOW  = 2'h0,
		VAR_HIGH = 2'h1,
		VAR_BOTH = 2'h2
	} variant_t;

	// Asynchronous inputs, carried together through the synchroniser.
	typedef struct packed {
		logic supplyLow;
		logic manualN;
		logic manualFloat;
		logic pfAbove;
		logic kick;
		logic kickFloat;
	} syncIn_t;

	// Synchroniser reset value: supply assumed low, manual reset idle high.
	localparam syncIn_t SYNC_INIT = '{supplyLow: 1'b1, manualN: 1'b1, manualFloat: 1'b0,
	                                  pfAbove: 1'b1, kick: 1'b0, kickFloat: 1'b0};

	// Complete state of the supervisor.
	typedef struct packed {
		logic [31:0]        tickCnt;
		logic               inReset;
		logic [PULSE_W-1:0] pulseCnt;
		logic [WDOG_W-1:0]  wdCnt;
		logic               wdExpired;
		logic               kickPrev;
		logic               rstOutN;
		logic               rstOut;
		logic               wdoN;
		logic               pfoN;
	} state_t;

endpackage
`default_nettype wire

// ===== sync_two_flop.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the caller reads only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rstn,
	// Levels in and out.
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [1:0][W-1:0] stage_q;

	// The first stage feeds only the second.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage_q <= {INIT, INIT};
		end else begin
			stage_q <= {stage_q[0], d};
		end
	end

	assign q = stage_q[1];

endmodule // sync_two_flop
`default_nettype wire

// ===== supply_supervisor_watchdog.sv
// Supply supervisor: stretched reset, watchdog timer and power-fail output.
// Assumes comparator results and pad float sensing arrive as asynchronous digital levels.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog #(
	parameter supervisor_pkg::variant_t VARIANT     = supervisor_pkg::VAR_LOW,
	parameter int                       TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic resetn,
	// Comparator indications and pins.
	input  wire logic supplyLow,
	input  wire logic manual_reset_n,
	input  wire logic manualResetFloat,
	input  wire logic power_fail_sense_in,
	input  wire logic watchdog_kick_in,
	input  wire logic watchdogKickFloat,
	// Outputs to the processor.
	output var  logic resetOutN,
	output var  logic resetOut,
	output var  logic watchdog_timeout_out_n,
	output var  logic power_fail_out_n
);
	import supervisor_pkg::*;

	localparam logic HAS_WDOG   = (VARIANT != VAR_BOTH);
	localparam logic HAS_LOW    = (VARIANT != VAR_HIGH);
	localparam logic HAS_HIGH   = (VARIANT != VAR_LOW);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	logic [1:0] rstSync_q;
	logic       rstnInt;
	syncIn_t    rawIn;
	syncIn_t    syn;
	state_t     s_q;
	state_t     s_d;
	logic       tick;
	logic       manualActive;
	logic       holdReset;
	logic       kickEdge;
	logic       wdClear;

	// Reset is released through two flops; assertion stays asynchronous.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstnInt = rstSync_q[1];

	// All pin and comparator levels pass two flops before use.
	assign rawIn = '{supplyLow: supplyLow, manualN: manual_reset_n, manualFloat: manualResetFloat,
	                 pfAbove: power_fail_sense_in, kick: watchdog_kick_in, kickFloat: watchdogKickFloat};

	sync_two_flop #(
		.W    ($bits(syncIn_t)),
		.INIT (SYNC_INIT)
	) inSync (
		.clk  (clk),
		.rstn (rstnInt),
		.d    (rawIn),
		.q    (syn)
	);

	// Free-running time base tick and derived reset and watchdog causes.
	assign tick         = (s_q.tickCnt == TICK_LAST);
	assign manualActive = !syn.manualN && !syn.manualFloat;
	assign holdReset    = syn.supplyLow || manualActive;
	assign kickEdge     = (syn.kick != s_q.kickPrev);
	assign wdClear      = s_q.inReset || syn.kickFloat || kickEdge || !HAS_WDOG;

	// Next-state logic for the whole block.
	always_comb begin
		s_d          = s_q;
		s_d.kickPrev = syn.kick;
		s_d.tickCnt  = tick ? 32'h0000_0000 : s_q.tickCnt + 32'h0000_0001;

		// Reset pulse: restarted while a cause holds, then counts ticks.
		if (holdReset) begin
			s_d.inReset  = 1'b1;
			s_d.pulseCnt = '0;
		end else if (s_q.inReset && tick) begin
			if (s_q.pulseCnt == RESET_TICKS - PULSE_W'(1)) begin
				s_d.inReset = 1'b0;
			end else begin
				s_d.pulseCnt = s_q.pulseCnt + PULSE_W'(1);
			end
		end

		// Watchdog: cleared by any clear event, otherwise counts ticks.
		if (wdClear) begin
			s_d.wdCnt     = '0;
			s_d.wdExpired = 1'b0;
		end else if (tick && !s_q.wdExpired) begin
			if (s_q.wdCnt == WDOG_TICKS - WDOG_W'(1)) begin
				s_d.wdExpired = 1'b1;
			end else begin
				s_d.wdCnt = s_q.wdCnt + WDOG_W'(1);
			end
		end

		// Registered outputs.
		s_d.rstOutN = HAS_LOW ? !s_d.inReset : 1'b1;
		s_d.rstOut  = HAS_HIGH ? s_d.inReset : 1'b0;
		s_d.wdoN    = HAS_WDOG ? !(syn.supplyLow || s_d.wdExpired) : 1'b1;
		s_d.pfoN    = syn.pfAbove;
	end

	// State register.
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			s_q           <= '0;
			s_q.inReset   <= 1'b1;
			s_q.rstOutN   <= !HAS_LOW;
			s_q.rstOut    <= HAS_HIGH;
			s_q.wdoN      <= 1'b1;
			s_q.pfoN      <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign resetOutN              = s_q.rstOutN;
	assign resetOut               = s_q.rstOut;
	assign watchdog_timeout_out_n = s_q.wdoN;
	assign power_fail_out_n       = s_q.pfoN;

	// Checks on the relations between causes and outputs.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstnInt);

	hold_low_a: assert property (syn.supplyLow |=> s_q.inReset)
		else $error("reset not held during low supply");
	release_time_a: assert property ($fell(s_q.inReset) |-> $past(tick) && $past(s_q.pulseCnt) == RESET_TICKS - PULSE_W'(1))
		else $error("reset released before the full pulse");
	complement_a: assert property (VARIANT == VAR_BOTH |-> resetOut == !resetOutN)
		else $error("reset outputs not complementary");
	manual_start_a: assert property (manualActive |=> (s_q.inReset && s_q.pulseCnt == '0))
		else $error("manual reset did not start a pulse");
	manual_float_a: assert property (syn.manualFloat && !syn.supplyLow |-> !holdReset)
		else $error("floating manual reset treated as active");
	timeout_set_a: assert property (HAS_WDOG && tick && !wdClear && s_q.wdCnt == WDOG_TICKS - WDOG_W'(1)
		|=> s_q.wdExpired && !watchdog_timeout_out_n)
		else $error("watchdog did not time out");
	kick_float_a: assert property (syn.kickFloat |=> !s_q.wdExpired && s_q.wdCnt == '0)
		else $error("floating kick did not disable watchdog");
	wdog_clear_a: assert property (kickEdge |=> s_q.wdCnt == '0)
		else $error("kick edge did not clear count");
	timeout_hold_a: assert property (s_q.wdExpired && !wdClear |=> s_q.wdExpired)
		else $error("timeout dropped without a clear");
	supply_wdo_a: assert property ($fell(syn.supplyLow) |=> watchdog_timeout_out_n)
		else $error("watchdog output not released on recovery");
	power_fail_a: assert property (##1 power_fail_out_n == $past(syn.pfAbove))
		else $error("power-fail output wrong");
	no_wdog_a: assert property (VARIANT == VAR_BOTH |-> watchdog_timeout_out_n && !s_q.wdExpired)
		else $error("dual variant has active watchdog");
	reset_idle_a: assert property (s_q.inReset && !syn.supplyLow |=> s_q.wdCnt == '0 && watchdog_timeout_out_n)
		else $error("watchdog active during reset");

	pulse_done_c: cover property ($fell(s_q.inReset));
	wdog_out_c: cover property ($fell(watchdog_timeout_out_n) && !syn.supplyLow);
	dip_restart_c: cover property (s_q.inReset && s_q.pulseCnt != '0 ##1 syn.supplyLow);

endmodule // supply_supervisor_watchdog
`default_nettype wire

// ===== cpu_kick_model.sv
// Behavioural model of the supervised processor, which toggles the watchdog kick line.
// Assumes the supervisor's clock; the processor kicks only while its reset input is high.
`timescale 1ns/1ps
`default_nettype none
module cpu_kick_model #(
	parameter int PERIOD = 1000
) (
	// Clock and the processor's reset input.
	input  wire logic clk,
	input  wire logic resetInN,
	// Control from the bench.
	input  wire logic kickEn,
	input  wire logic lineFloat,
	// Kick line to the supervisor.
	output var  logic kick
);
	int   cnt  = 0;
	logic lvl  = 1'b0;
	// Toggle well inside the timeout while enabled and out of reset.
	always @(posedge clk) begin
		cnt  <= (kickEn && resetInN && cnt < PERIOD - 1) ? cnt + 1 : 0;
		if (kickEn && resetInN && cnt == PERIOD - 1) begin
			lvl <= ~lvl;
		end
	end
	// A released line settles at the inverse of its last driven level and then stays still.
	// Only the float sense can then keep the watchdog quiet, since no further edges arrive.
	assign kick = lineFloat ? ~lvl : lvl;
endmodule // cpu_kick_model
`default_nettype wire

// ===== supply_supervisor_watchdog_test.sv
// Self-checking bench for the supply supervisor with a processor model on its outputs.
// Assumes a 4-cycle tick: reset pulse 800 cycles, watchdog timeout 6400 cycles.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_test;
	import supervisor_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, supplyLow = 1'b1, manN = 1'b1, manFlt = 1'b0;
	logic pfSense = 1'b1, kickFlt = 1'b0, kickEn = 1'b0, kick;
	logic rstN, rst, wdoN, pfoN, bothRstN, bothRst, bothWdoN;
	logic highRstN, highRst, highWdoN;
	int   badCount = 0, samplesChecked = 0, n;
	// Clock of 5 ns period.
	always #2.5 clk = ~clk;
	// Default single-polarity variant and a dual-polarity variant on the same pins.
	supply_supervisor_watchdog #(.VARIANT(VAR_LOW), .TICK_CYCLES(4)) dut (.clk(clk), .resetn(resetn),
		.supplyLow(supplyLow), .manual_reset_n(manN), .manualResetFloat(manFlt), .power_fail_sense_in(pfSense),
		.watchdog_kick_in(kick), .watchdogKickFloat(kickFlt), .resetOutN(rstN), .resetOut(rst),
		.watchdog_timeout_out_n(wdoN), .power_fail_out_n(pfoN));
	supply_supervisor_watchdog #(.VARIANT(VAR_BOTH), .TICK_CYCLES(4)) dutBoth (.clk(clk), .resetn(resetn),
		.supplyLow(supplyLow), .manual_reset_n(manN), .manualResetFloat(manFlt), .power_fail_sense_in(pfSense),
		.watchdog_kick_in(kick), .watchdogKickFloat(kickFlt), .resetOutN(bothRstN), .resetOut(bothRst),
		.watchdog_timeout_out_n(bothWdoN), .power_fail_out_n());
	// High-polarity variant with a watchdog on the same pins.
	supply_supervisor_watchdog #(.VARIANT(VAR_HIGH), .TICK_CYCLES(4)) dutHigh (.clk(clk), .resetn(resetn),
		.supplyLow(supplyLow), .manual_reset_n(manN), .manualResetFloat(manFlt), .power_fail_sense_in(pfSense),
		.watchdog_kick_in(kick), .watchdogKickFloat(kickFlt), .resetOutN(highRstN), .resetOut(highRst),
		.watchdog_timeout_out_n(highWdoN), .power_fail_out_n());
	cpu_kick_model #(.PERIOD(1000)) cpu (.clk(clk), .resetInN(rstN), .kickEn(kickEn), .lineFloat(kickFlt),
		.kick(kick));
	// Compares one value and counts the comparison.
	task automatic check(input string what, input logic seen, input logic exp);
		samplesChecked++;
		if (seen !== exp) begin
			badCount++;
			$display("FAIL %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// Picks an output: 0 low reset, 1 dual high reset, 2 watchdog, 3 power fail.
	function automatic logic pick(input int which);
		return which == 0 ? rstN : which == 1 ? bothRst : which == 2 ? wdoN : pfoN;
	endfunction
	// Waits a bounded number of cycles for an output level and returns the cycles taken.
	task automatic waitOut(input int which, input logic val, input int limit, output int cycles);
		for (cycles = 1; cycles <= limit; cycles++) begin
			@(posedge clk);
			#1;
			if (pick(which) === val) return;
		end
		check("wait bound", 1'b0, 1'b1);
		closeOut();
	endtask
	// Requires an output to hold one level for a number of cycles.
	task automatic holdOut(input int which, input logic val, input int cycles);
		for (int i = 0; i < cycles; i++) begin
			@(posedge clk);
			#1;
			if (pick(which) !== val) begin
				check("held level", pick(which), val);
				return;
			end
		end
		check("held level", pick(which), val);
	endtask
	// Power-up with the supply low, then recovery and the stretched pulse.
	task automatic testPowerUp();
		repeat (20) @(posedge clk);
		#1;
		check("rstN low supply", rstN, 1'b0);
		check("dual complement", bothRst, ~bothRstN);
		check("wdo low supply", wdoN, 1'b0);
		check("high variant reset", highRst, 1'b1);
		check("high variant low out", highRstN, 1'b1);
		@(posedge clk) supplyLow <= 1'b0;
		waitOut(2, 1'b1, 6, n);
		waitOut(0, 1'b1, 820, n);
		check("pulse length", n >= 790, 1'b1);
		check("dual release", bothRst, 1'b0);
		check("low variant high out", rst, 1'b0);
		check("high variant release", highRst, 1'b0);
		$display("power-up test done");
	endtask
	// Manual reset, float masking and a supply dip inside the pulse.
	task automatic testManual();
		@(posedge clk) {manFlt, manN} <= 2'b10;
		holdOut(0, 1'b1, 20);
		@(posedge clk) manFlt <= 1'b0;
		waitOut(0, 1'b0, 5, n);
		@(posedge clk) manN <= 1'b1;
		repeat (400) @(posedge clk);
		supplyLow <= 1'b1;
		repeat (10) @(posedge clk);
		supplyLow <= 1'b0;
		waitOut(0, 1'b1, 820, n);
		check("dip extends pulse", n >= 790, 1'b1);
		$display("manual test done");
	endtask
	// Kicking keeps the watchdog quiet; silence times out; a kick clears it.
	task automatic testWatchdog();
		@(posedge clk) kickEn <= 1'b1;
		holdOut(2, 1'b1, 8000);
		@(posedge clk) kickEn <= 1'b0;
		waitOut(2, 1'b0, 6500, n);
		check("timeout length", n >= 6300, 1'b1);
		holdOut(2, 1'b0, 200);
		check("dual no watchdog", bothWdoN, 1'b1);
		check("high variant timeout", highWdoN, 1'b0);
		@(posedge clk) kickEn <= 1'b1;
		waitOut(2, 1'b1, 1010, n);
		@(posedge clk) {kickFlt, kickEn} <= 2'b10;
		holdOut(2, 1'b1, 7000);
		@(posedge clk) kickFlt <= 1'b0;
		$display("watchdog test done");
	endtask
	// Power-fail output follows the comparator.
	task automatic testPowerFail();
		@(posedge clk) pfSense <= 1'b0;
		waitOut(3, 1'b0, 5, n);
		@(posedge clk) pfSense <= 1'b1;
		waitOut(3, 1'b1, 5, n);
		$display("power-fail test done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic closeOut();
		$display("checked %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence after 16 reset cycles.
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		testPowerUp();
		testManual();
		testWatchdog();
		testPowerFail();
		closeOut();
	end
endmodule // supply_supervisor_watchdog_test
`default_nettype wire
